// ### src/dtp_top.sv
/*
 * Dual 8-bit timer/counter: interval timer, event counter, programmable
 * divider and PWM per channel, programmed over an AXI4-Lite slave.
 * Assumes event pins and the sub-oscillator level are synchronous to clk;
 * one write and one read outstanding at a time.
 */
`timescale 1ns/1ns
// Overview of operation
// - timer mode: count internal ticks, on period match pulse irq, clear, continue
// - period register unbuffered, takes effect at once; software leaves it alone while running
// - event mode: count falling edges of event pin, match pulses irq and clears
// - divider mode: match toggles flip-flop, clears counter, pulses irq; pin is inverse
// - flip-flop loads preset bit when stopped; reset clears it to zero
// - stopping keeps pin level; preset ignored in the stopping write itself
// - pwm: duty match toggles flip-flop; overflow toggles, clears, pulses irq
// - pulse-width pin always shows inverse of flip-flop
// - duty double-buffered: running loads at match irq, stopped loads at once
// - duty read returns the active compare value
// - timer and divider ticks: /2^7, /2^5, /2^3, slowest /2^11 or sub/2^3
// - pwm also accepts sub clock, main/2 and main; low speed keeps sub taps
// - control bit 3 starts and stops; bit 7 presets flip-flop
// - clock select bits 6:4, mode bits 2:0, timer 000, divider 001
module dtp_top
    import dtp_pkg::*;
#(
    parameter int CHANNELS = 2,
    parameter int ADDR_W   = 8
) (
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    // AXI4-Lite slave
    input  wire logic                  awvalid,
    output logic                       awready,
    input  wire logic [ADDR_W-1:0]     awaddr,
    input  wire logic [2:0]            awprot,
    input  wire logic                  wvalid,
    output logic                       wready,
    input  wire logic [DTP_DATA_W-1:0] wdata,
    input  wire logic [3:0]            wstrb,
    output logic                       bvalid,
    input  wire logic                  bready,
    output logic      [1:0]            bresp,
    input  wire logic                  arvalid,
    output logic                       arready,
    input  wire logic [ADDR_W-1:0]     araddr,
    input  wire logic [2:0]            arprot,
    output logic                       rvalid,
    input  wire logic                  rready,
    output logic      [DTP_DATA_W-1:0] rdata,
    output logic      [1:0]            rresp,
    // pins
    input  wire logic                  subOscLevel,
    input  wire logic [CHANNELS-1:0]   eventInPin,
    output logic      [CHANNELS-1:0]   dividerOutPin,
    output logic      [CHANNELS-1:0]   pulseWidthPin,
    output logic      [CHANNELS-1:0]   channelMatchIrq
);

    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks

    generate
        if (CHANNELS < 1 || CHANNELS > 2) begin : g_badChannels
            $error("CHANNELS must be 1 or 2");
        end
        if (ADDR_W < 6 || ADDR_W > 32) begin : g_badAddr
            $error("ADDR_W must be 6 to 32");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // address decoding, shared by the write and read paths

    function automatic dtp_dec_s decodeReg(input logic [ADDR_W-1:0] addr);
        logic [7:0] low;
        dtp_dec_s   dec;
        low      = 8'(addr);
        dec.chan = low[4];
        dec.kind = DTP_RK_NONE;
        if (32'(addr) > 32'h0000_00ff) begin
            dec.kind = DTP_RK_NONE;
        end else if (low == DTP_OFF_CONFIG) begin
            dec.kind = DTP_RK_CONFIG;
        end else if (low == DTP_OFF_STATUS) begin
            dec.kind = DTP_RK_STATUS;
        end else if (32'(low[7:4]) >= CHANNELS) begin
            dec.kind = DTP_RK_NONE;
        end else if ((low & ~DTP_CH_STRIDE) == DTP_OFF_CTRL) begin
            dec.kind = DTP_RK_CTRL;
        end else if ((low & ~DTP_CH_STRIDE) == DTP_OFF_PERIOD) begin
            dec.kind = DTP_RK_PERIOD;
        end else if ((low & ~DTP_CH_STRIDE) == DTP_OFF_DUTY) begin
            dec.kind = DTP_RK_DUTY;
        end
        return dec;
    endfunction : decodeReg

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path

    logic [ADDR_W-1:0] wrAddr;
    logic [7:0]        wrByte;
    logic              wrLane0;
    logic              wrFire;
    dtp_dec_s          wrDec;

    // both halves held and no response pending
    assign wrFire = !awready && !wready && !bvalid;
    assign wrDec  = decodeReg(wrAddr);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            awready <= 1'b1;
            wrAddr  <= '0;
        end else if (awvalid && awready) begin
            awready <= 1'b0;
            wrAddr  <= awaddr;
        end else if (bvalid && bready) begin
            awready <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wready  <= 1'b1;
            wrByte  <= '0;
            wrLane0 <= 1'b0;
        end else if (wvalid && wready) begin
            wready  <= 1'b0;
            wrByte  <= wdata[7:0];
            wrLane0 <= wstrb[0];
        end else if (bvalid && bready) begin
            wready  <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bvalid <= 1'b0;
            bresp  <= DTP_RESP_OKAY;
        end else if (wrFire) begin
            bvalid <= 1'b1;
            bresp  <= (wrDec.kind == DTP_RK_NONE) ? DTP_RESP_SLVERR : DTP_RESP_OKAY;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    logic wrGo;
    assign wrGo = wrFire && wrLane0;

    ////////////////////////////////////////////////////////////////////////////
    // global configuration and prescaler

    logic [1:0] cfgReg;
    logic [7:0] tickVec;
    logic [CHANNELS-1:0] eventFall;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfgReg <= DTP_CONFIG_RST;
        end else if (wrGo && wrDec.kind == DTP_RK_CONFIG) begin
            cfgReg <= wrByte[1:0];
        end
    end

    dtp_prescaler u_prescaler (
        .clk         (clk),
        .rst_b       (rst_b),
        .subOscLevel (subOscLevel),
        .tapSel      (cfgReg[DTP_CFG_TAPSEL]),
        .lowSpeed    (cfgReg[DTP_CFG_LOWSPEED]),
        .tickVec     (tickVec)
    );

    // relies on the source holding each level two machine cycles
    dtp_fall_detect #(.W(CHANNELS)) u_eventEdge (
        .clk   (clk),
        .rst_b (rst_b),
        .level (eventInPin),
        .fall  (eventFall)
    );

    ////////////////////////////////////////////////////////////////////////////
    // channels

    dtp_ctrl_s [CHANNELS-1:0] ctrl;
    logic [CHANNELS-1:0][7:0] period;
    logic [CHANNELS-1:0][7:0] activeDuty;
    logic [CHANNELS-1:0][7:0] count;
    logic [CHANNELS-1:0]      pinLevel;

    genvar c;
    generate
        for (c = 0; c < CHANNELS; c++) begin : g_chan
            logic       hitCh;
            logic       ctrlWr;
            logic       periodWr;
            logic       dutyWr;
            logic       tick;
            logic       match;
            logic       overflow;
            logic       dutyHit;
            logic [7:0] bufDuty;
            logic [7:0] countInc;

            assign hitCh    = wrGo && (32'(wrDec.chan) == c);
            assign ctrlWr   = hitCh && wrDec.kind == DTP_RK_CTRL;
            assign periodWr = hitCh && wrDec.kind == DTP_RK_PERIOD;
            assign dutyWr   = hitCh && wrDec.kind == DTP_RK_DUTY;
            assign countInc = count[c] + 8'h01;

            // fast taps and the sub clock exist for pwm only
            always_comb begin
                tick = 1'b0;
                if (!ctrl[c].run) begin
                    tick = 1'b0;
                end else if (ctrl[c].mode == DTP_MODE_TIMER
                             && ctrl[c].clkSel == DTP_CKS_EVENT) begin
                    tick = eventFall[c];
                end else if (ctrl[c].clkSel == DTP_CKS_EVENT) begin
                    tick = 1'b0;
                end else if (ctrl[c].mode == DTP_MODE_PWM) begin
                    tick = tickVec[ctrl[c].clkSel];
                end else if (ctrl[c].clkSel <= DTP_CKS_DIV3) begin
                    tick = tickVec[ctrl[c].clkSel];
                end
            end

            assign match    = tick && ctrl[c].mode != DTP_MODE_PWM
                              && countInc == period[c];
            assign overflow = tick && ctrl[c].mode == DTP_MODE_PWM
                              && count[c] == 8'hff;
            assign dutyHit  = tick && ctrl[c].mode == DTP_MODE_PWM
                              && !overflow && countInc == activeDuty[c];

            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    ctrl[c] <= DTP_CTRL_RST;
                end else if (ctrlWr) begin
                    ctrl[c] <= wrByte;
                end
            end

            // unbuffered: a write lands on the very next compare
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    period[c] <= DTP_PERIOD_RST;
                end else if (periodWr) begin
                    period[c] <= wrByte;
                end
            end

            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    count[c] <= '0;
                end else if (!ctrl[c].run) begin
                    count[c] <= '0;
                end else if (match || overflow) begin
                    count[c] <= '0;
                end else if (tick && ctrl[c].mode <= DTP_MODE_PWM) begin
                    count[c] <= countInc;
                end
            end

            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    channelMatchIrq[c] <= 1'b0;
                end else begin
                    channelMatchIrq[c] <= match || overflow;
                end
            end

            // pin stores the inverse of the flip-flop; a stopping write has run
            // still set, so its preset bit is ignored and the pin holds
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    pinLevel[c] <= 1'b1;
                end else if (ctrlWr && !ctrl[c].run) begin
                    pinLevel[c] <= !wrByte[DTP_CTRL_PRESET];
                end else if (match && ctrl[c].mode == DTP_MODE_DIVIDER) begin
                    pinLevel[c] <= !pinLevel[c];
                end else if (overflow || dutyHit) begin
                    pinLevel[c] <= !pinLevel[c];
                end
            end

            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    bufDuty <= DTP_DUTY_RST;
                end else if (dutyWr) begin
                    bufDuty <= wrByte;
                end
            end

            // a write colliding with overflow: old buffer moves, new one waits
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    activeDuty[c] <= DTP_DUTY_RST;
                end else if (dutyWr && !ctrl[c].run) begin
                    activeDuty[c] <= wrByte;
                end else if (overflow) begin
                    activeDuty[c] <= bufDuty;
                end
            end

            assign dividerOutPin[c] = pinLevel[c];
            assign pulseWidthPin[c] = pinLevel[c];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read path, answer one cycle after the address is taken

    function automatic logic [DTP_DATA_W-1:0] readMux(input dtp_dec_s dec);
        logic [DTP_DATA_W-1:0] val;
        val = '0;
        case (dec.kind)
            DTP_RK_CTRL:   val[7:0] = ctrl[dec.chan];
            DTP_RK_PERIOD: val[7:0] = period[dec.chan];
            DTP_RK_DUTY:   val[7:0] = activeDuty[dec.chan];
            DTP_RK_CONFIG: val[1:0] = cfgReg;
            DTP_RK_STATUS: begin
                for (int i = 0; i < CHANNELS; i++) begin
                    val[DTP_ST_CNT_LO + 8*i +: 8] = count[i];
                    val[DTP_ST_FF_LO + i]         = !pinLevel[i];
                    val[DTP_ST_RUN_LO + i]        = ctrl[i].run;
                end
            end
            default:       val = '0;
        endcase
        return val;
    endfunction : readMux

    dtp_dec_s rdDec;
    assign rdDec = decodeReg(araddr);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= DTP_RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= readMux(rdDec);
            rresp   <= (rdDec.kind == DTP_RK_NONE) ? DTP_RESP_SLVERR : DTP_RESP_OKAY;
        end else if (rvalid && rready) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
        end
    end

endmodule : dtp_top

// ### src/dtp_pkg.sv
/*
 * Shared constants and types for the dual 8-bit timer/counter block:
 * register map, control field layout, mode and clock-select codes, reset values.
 * Assumes AXI4-Lite with 32-bit data, one register per aligned word.
 */
package dtp_pkg;

    localparam int          DTP_CNT_W        = 8;
    localparam int          DTP_DATA_W       = 32;

    // register map, byte addresses
    localparam logic [7:0]  DTP_CH_STRIDE    = 8'h10;
    localparam logic [7:0]  DTP_OFF_CTRL     = 8'h00;
    localparam logic [7:0]  DTP_OFF_PERIOD   = 8'h04;
    localparam logic [7:0]  DTP_OFF_DUTY     = 8'h08;
    localparam logic [7:0]  DTP_OFF_CONFIG   = 8'h20;
    localparam logic [7:0]  DTP_OFF_STATUS   = 8'h24;

    // control register fields
    localparam int          DTP_CTRL_PRESET  = 7;
    localparam int          DTP_CTRL_CKS_LO  = 4;
    localparam int          DTP_CTRL_RUN     = 3;
    localparam int          DTP_CTRL_MODE_LO = 0;

    // config register fields
    localparam int          DTP_CFG_TAPSEL   = 0;
    localparam int          DTP_CFG_LOWSPEED = 1;

    // status register fields
    localparam int          DTP_ST_CNT_LO    = 0;
    localparam int          DTP_ST_FF_LO     = 16;
    localparam int          DTP_ST_RUN_LO    = 18;

    // reset values
    localparam logic [7:0]  DTP_CTRL_RST     = 8'h00;
    localparam logic [7:0]  DTP_PERIOD_RST   = 8'h00;
    localparam logic [7:0]  DTP_DUTY_RST     = 8'h00;
    localparam logic [1:0]  DTP_CONFIG_RST   = 2'h0;

    // clock select codes
    localparam logic [2:0]  DTP_CKS_SLOWEST  = 3'h0;
    localparam logic [2:0]  DTP_CKS_DIV7     = 3'h1;
    localparam logic [2:0]  DTP_CKS_DIV5     = 3'h2;
    localparam logic [2:0]  DTP_CKS_DIV3     = 3'h3;
    localparam logic [2:0]  DTP_CKS_SUB      = 3'h4;
    localparam logic [2:0]  DTP_CKS_DIV1     = 3'h5;
    localparam logic [2:0]  DTP_CKS_MAIN     = 3'h6;
    localparam logic [2:0]  DTP_CKS_EVENT    = 3'h7;

    // prescaler tap widths (main or sub clock divided by 2^n)
    localparam int          DTP_PRE_W        = 11;
    localparam int          DTP_SUB_DIV_W    = 3;

    localparam logic [1:0]  DTP_RESP_OKAY    = 2'h0;
    localparam logic [1:0]  DTP_RESP_SLVERR  = 2'h2;

    typedef enum logic [2:0] {
        DTP_MODE_TIMER   = 3'h0,
        DTP_MODE_DIVIDER = 3'h1,
        DTP_MODE_PWM     = 3'h2
    } dtp_mode_e;

    typedef struct packed {
        logic       preset;
        logic [2:0] clkSel;
        logic       run;
        logic [2:0] mode;
    } dtp_ctrl_s;

    typedef enum logic [2:0] {
        DTP_RK_CTRL   = 3'h0,
        DTP_RK_PERIOD = 3'h1,
        DTP_RK_DUTY   = 3'h3,
        DTP_RK_CONFIG = 3'h2,
        DTP_RK_STATUS = 3'h6,
        DTP_RK_NONE   = 3'h7
    } dtp_reg_e;

    typedef struct packed {
        dtp_reg_e kind;
        logic     chan;
    } dtp_dec_s;

endpackage : dtp_pkg

// ### src/dtp_fall_detect.sv
/*
 * Falling-edge detector on synchronous level inputs, one pulse per edge.
 * Assumes inputs are already synchronous to clk.
 */
`timescale 1ns/1ns
module dtp_fall_detect #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] level,
    output logic      [W-1:0] fall
);
    import dtp_pkg::*;

    logic [W-1:0] prevLevel;

    // reset to high, so a pin low at reset gives one edge as reset ends
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prevLevel <= '1;
        end else begin
            prevLevel <= level;
        end
    end

    assign fall = prevLevel & ~level;

endmodule : dtp_fall_detect

// ### src/dtp_prescaler.sv
/*
 * Prescaler: one-cycle count ticks derived from clk (main oscillator) and
 * from the sampled sub-oscillator level. Index of tickVec is the clock select code.
 * Assumes subOscLevel is synchronous to clk and far slower than it.
 */
`timescale 1ns/1ns
module dtp_prescaler
    import dtp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       subOscLevel,
    input  wire logic       tapSel,
    input  wire logic       lowSpeed,
    output logic      [7:0] tickVec
);

    logic [DTP_PRE_W-1:0]     divCnt;
    logic [DTP_SUB_DIV_W-1:0] subCnt;
    logic                     subTick;
    logic                     mainOn;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            divCnt <= '0;
        end else begin
            divCnt <= divCnt + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            subCnt <= '0;
        end else if (subTick) begin
            subCnt <= subCnt + 1'b1;
        end
    end

    dtp_fall_detect #(.W(1)) u_subEdge (
        .clk   (clk),
        .rst_b (rst_b),
        .level (subOscLevel),
        .fall  (subTick)
    );

    // main-oscillator taps are unusable in low speed modes
    assign mainOn = !lowSpeed;
    always_comb begin
        tickVec                = '0;
        tickVec[DTP_CKS_SLOWEST] = (tapSel || lowSpeed) ? (subTick && (&subCnt))
                                                        : (mainOn && (&divCnt));
        tickVec[DTP_CKS_DIV7]  = mainOn && (&divCnt[6:0]);
        tickVec[DTP_CKS_DIV5]  = mainOn && (&divCnt[4:0]);
        tickVec[DTP_CKS_DIV3]  = mainOn && (&divCnt[2:0]);
        tickVec[DTP_CKS_SUB]   = subTick;
        tickVec[DTP_CKS_DIV1]  = mainOn && divCnt[0];
        tickVec[DTP_CKS_MAIN]  = mainOn;
    end

endmodule : dtp_prescaler

// ### tb/dtp_top_properties.sv
/* checker for the dual timer top: bus handshake and pin/irq properties.
   assumes it is bound into dtp_top, one clock domain, reset rst_b */
`timescale 1ns/1ns
module dtp_top_checker
    import dtp_pkg::*;
#(parameter int CHANNELS = 2, parameter int ADDR_W = 8) (
    input wire logic                  clk,
    input wire logic                  rst_b,
    input wire logic                  awvalid,
    input wire logic                  awready,
    input wire logic                  wvalid,
    input wire logic                  wready,
    input wire logic                  bvalid,
    input wire logic                  bready,
    input wire logic [1:0]            bresp,
    input wire logic                  arvalid,
    input wire logic                  arready,
    input wire logic                  rvalid,
    input wire logic                  rready,
    input wire logic [DTP_DATA_W-1:0] rdata,
    input wire logic [CHANNELS-1:0]   dividerOutPin,
    input wire logic [CHANNELS-1:0]   pulseWidthPin,
    input wire logic [CHANNELS-1:0]   channelMatchIrq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////////
    a_irq_pulse: assert property (channelMatchIrq[0] |=> !channelMatchIrq[0])
        else $error("irq high for more than one cycle");
    a_irq_last: assert property (channelMatchIrq[CHANNELS-1] |=> !channelMatchIrq[CHANNELS-1])
        else $error("last channel irq too long");
    a_pins_pair: assert property (dividerOutPin == pulseWidthPin)
        else $error("output pins disagree");
    a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped early");
    a_b_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write response late");
    a_r_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    a_r_lock: assert property (rvalid |-> !arready)
        else $error("read address open during answer");
    a_w_lock: assert property (bvalid |-> !awready && !wready)
        else $error("write channels open during answer");
    c_irq: cover property ($rose(channelMatchIrq[0]));
    c_pin: cover property ($fell(pulseWidthPin[0]));
    c_err: cover property (bvalid && bresp == DTP_RESP_SLVERR);
endmodule : dtp_top_checker

bind dtp_top dtp_top_checker #(.CHANNELS(CHANNELS), .ADDR_W(ADDR_W)) u_dtp_top_checker (
    .clk(clk), .rst_b(rst_b), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
    .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .dividerOutPin(dividerOutPin), .pulseWidthPin(pulseWidthPin),
    .channelMatchIrq(channelMatchIrq));

// ### tb/dtp_event_source.sv
/* far side model: event pin pulses on request and a free sub-oscillator.
   assumes fire is a one-cycle request, spaced at least 8 cycles apart */
`timescale 1ns/1ns
module dtp_event_source (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic fire,
    output logic      evPin,
    output logic      subOsc
);
    logic [3:0] hold;
    logic [2:0] subDiv;
    // low lasts 3 cycles and high at least 4, above the two-cycle minimum
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hold  <= 4'h0;
            evPin <= 1'b1;
        end else if (hold != 4'h0) begin
            hold  <= hold - 4'h1;
            evPin <= (hold <= 4'h4);
        end else if (fire) begin
            hold  <= 4'h6;
            evPin <= 1'b0;
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) subDiv <= 3'h0;
        else subDiv <= subDiv + 3'h1;
    end
    assign subOsc = subDiv[2];
endmodule : dtp_event_source

// ### tb/tb.sv
/* self-checking bench for dtp_top: AXI4-Lite tasks and mode scenarios.
   assumes the event source model drives the event pins */
`timescale 1ns/1ns
module tb
    import dtp_pkg::*;
;
    logic clk = 0, rst_b = 0, fire = 0, ev, sub;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic [1:0] bresp, rresp, r, dp, pw, irq;
    int error_cnt = 0, checks = 0, n, k, irqCnt = 0;
    logic p;
    dtp_top u_dtp_top (.clk(clk), .rst_b(rst_b), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(4'h1), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .subOscLevel(sub), .eventInPin({ev, ev}),
        .dividerOutPin(dp), .pulseWidthPin(pw), .channelMatchIrq(irq));
    dtp_event_source u_dtp_event_source (.clk(clk), .rst_b(rst_b), .fire(fire),
        .evPin(ev), .subOsc(sub));
    always #20 clk = ~clk;
    always @(posedge clk) if (irq[0] === 1'b1) irqCnt++;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
        bready <= 0;
        chk("bresp", DTP_RESP_OKAY, bresp);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge clk);
        araddr <= a; arvalid <= 1; rready <= 1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 0;
        end while (!rvalid);
        v = rdata; rs = rresp; rready <= 0;
    endtask : rd
    task automatic wirq(output int c);
        c = 0;
        do begin @(posedge clk); c++; end while (irq[0] !== 1'b1 && c < 1000);
    endtask : wirq
    task automatic pulse;
        fire <= 1; @(posedge clk); fire <= 0; repeat (10) @(posedge clk);
    endtask : pulse
    task automatic stop_test;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : stop_test
    initial begin #800000; error_cnt++; stop_test; end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1;
        @(posedge clk);
        chk("pins", 2'h3, pw);
        for (k = 0; k < 3; k++) begin rd(8'(4 * k), d, r); chk("rst", 0, d); end
        rd(8'h30, d, r); chk("unmapped", {30'h0, DTP_RESP_SLVERR}, {d[29:0], r});
        wr(DTP_OFF_PERIOD, 3);
        for (k = 1; k < 4; k++) begin
            wr(DTP_OFF_CTRL, 0);
            wr(DTP_OFF_CTRL, {1'b0, 3'(k), 4'h8});
            wirq(n); wirq(n); chk("tick", 3 << (9 - 2 * k), n);
        end
        wr(DTP_OFF_CTRL, 0); wr(DTP_OFF_PERIOD, 2); wr(DTP_OFF_CTRL, 8'h39);
        wirq(n); p = dp[0]; wirq(n);
        chk("div", {1'b1, 8'd16}, {p ^ dp[0], 8'(n)});
        p = pw[0]; wr(DTP_OFF_CTRL, 8'hb1); repeat (40) @(posedge clk);
        chk("hold", p, pw[0]);
        wr(DTP_OFF_CTRL, 8'h81); chk("preset", 0, pw[0]);
        wr(DTP_OFF_CTRL, 8'h01); chk("clear", 1, dp[0]);
        wr(DTP_OFF_CTRL, 8'h78); k = irqCnt;
        repeat (3) pulse; chk("ev3", 1, irqCnt - k);
        pulse; chk("ev4", 2, irqCnt - k);
        wr(DTP_OFF_CTRL, 0); wr(DTP_OFF_DUTY, 8'h40);
        rd(DTP_OFF_DUTY, d, r); chk("duty", 8'h40, d);
        wr(DTP_OFF_CTRL, 8'h6a);
        for (k = 0; k < 2; k++) begin
            wirq(n); p = pw[0]; n = 0;
            do begin @(posedge clk); n++; end while (pw[0] === p && n < 300);
            chk("run", 8'h40 << k, n);
            if (k == 0) begin
                wr(DTP_OFF_DUTY, 8'h80);
                rd(DTP_OFF_DUTY, d, r); chk("old", 8'h40, d);
                wirq(n); rd(DTP_OFF_DUTY, d, r); chk("new", 8'h80, d);
            end
        end
        // channel 1 on the slowest tap, taken from the sub clock divided by 8
        wr(DTP_OFF_CONFIG, 1); wr(DTP_CH_STRIDE + DTP_OFF_PERIOD, 1);
        wr(DTP_CH_STRIDE, 8'h08);
        for (k = 0; k < 2; k++) begin
            n = 0;
            do begin @(posedge clk); n++; end while (irq[1] !== 1'b1 && n < 1000);
        end
        chk("sub", 64, n);
        chk("pin1", 1, dp[1]);
        rd(DTP_OFF_STATUS, d, r); chk("st_run", 2'h3, d[19:18]);
        wr(DTP_OFF_CTRL, 0);
        stop_test;
    end
endmodule : tb
